// >>> design/tbt_consts.svh
// Purpose: named constants for the 10 Mb/s twisted-pair port control
// Assumes: core clock 125 MHz, bit period 100 ns
// Notes: register byte address is four times the register index
`ifndef TBT_CONSTS_SVH
`define TBT_CONSTS_SVH
`define TBT_CLK_NS 8
`define TBT_BIT_NS 100
`define TBT_SQ_WIN_NS 150
`define TBT_SQ_EOP_NS 200
`define TBT_CRS_DROP_NS 150
`define TBT_LP_WIDTH_NS 100
`define TBT_US_NS 1000
`define TBT_US_PER_MS 1000
`define TBT_JAB_MS 24
`define TBT_UNJAB_MS 256
`define TBT_LP_MS 16
`define TBT_LINK_LOSS_MS 150
// longest times round down, least times round up
`define TBT_SQ_WIN_CYC (`TBT_SQ_WIN_NS / `TBT_CLK_NS)
`define TBT_SQ_EOP_CYC (`TBT_SQ_EOP_NS / `TBT_CLK_NS + 1)
`define TBT_CRS_DROP_CYC (`TBT_CRS_DROP_NS / `TBT_CLK_NS)
`define TBT_LP_CYC ((`TBT_LP_WIDTH_NS + `TBT_CLK_NS - 1) / `TBT_CLK_NS)
`define TBT_US_CYC (`TBT_US_NS / `TBT_CLK_NS)
// half-bit enable: 20 MHz from 125 MHz as 4/25
`define TBT_HB_STEP 5'h04
`define TBT_HB_MOD 5'h19
`define TBT_IDX_LSTAT 6'h01
`define TBT_IDX_CFG10 6'h10
`define TBT_IDX_CFG11 6'h11
`define TBT_IDX_CTRL 6'h12
`define TBT_IDX_STAT 6'h13
`define TBT_B_LINKUP 2
`define TBT_B_JABDIS 4
`define TBT_B_POLREV 5
`define TBT_B_SQLOW 10
`define TBT_B_ANEN 0
`define TBT_B_REPT 3
`define TBT_F_MODE 2:1
`define TBT_F_ABIL 7:4
`define TBT_CTRL_RST 16'h00F1
`define TBT_POL_LP_N 3'h7
`define TBT_POL_EOP_N 3'h3
`endif

// >>> design/tbt_pkg.sv
// Purpose: types shared by the port control files
// Assumes: nothing
// Notes: mode code order follows the ability bit order
package tbt_pkg;
  typedef enum logic [1:0] {
    TBT_M10H = 2'b00,
    TBT_M10F = 2'b01,
    TBT_M100H = 2'b10,
    TBT_M100F = 2'b11
  } tbt_mode_e;
  typedef enum logic [1:0] {
    TBT_TX_IDLE = 2'b00,
    TBT_TX_ACT = 2'b01,
    TBT_TX_TAIL = 2'b11
  } tbt_txst_e;
  typedef enum logic [1:0] {
    TBT_SQ_IDLE = 2'b00,
    TBT_SQ_ONE = 2'b01,
    TBT_SQ_TWO = 2'b11,
    TBT_SQ_VALID = 2'b10
  } tbt_sqst_e;
  typedef struct packed {
    logic pos;
    logic neg;
  } tbt_sq_s;
  typedef struct packed {
    logic pulse;
    logic inv;
  } tbt_lp_s;
endpackage : tbt_pkg

// >>> design/tbt_squelch.sv
// Purpose: squelch timing qualifier for the receive path
// Assumes: comparator levels synchronous to core_clk
// Notes: valid drops after more than 200 ns without squelch
`timescale 1ns/100ps
`include "tbt_consts.svh"
module tbt_squelch
  import tbt_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire tbt_sq_s sq,
  input wire logic enable,
  output logic valid
);
  tbt_sqst_e st_r;
  logic first_pos_r;
  logic [4:0] cnt_r;
  logic any_sq;
  logic opp_sq;
  logic org_sq;

  // level decode against the first polarity seen
  assign any_sq = sq.pos | sq.neg;
  assign opp_sq = first_pos_r ? sq.neg : sq.pos;
  assign org_sq = first_pos_r ? sq.pos : sq.neg;
  assign valid = (st_r == TBT_SQ_VALID);

  // three-crossing qualifier and end-of-packet timer
  always_ff @(posedge core_clk) begin
    if (sys_rst || !enable) begin
      st_r <= TBT_SQ_IDLE;
      first_pos_r <= 1'b0;
      cnt_r <= 5'h00;
    end else begin
      case (st_r)
        TBT_SQ_IDLE: begin
          cnt_r <= 5'h00;
          if (any_sq) begin
            st_r <= TBT_SQ_ONE;
            first_pos_r <= sq.pos;
          end
        end
        TBT_SQ_ONE, TBT_SQ_TWO: begin
          if ((st_r == TBT_SQ_ONE) ? opp_sq : org_sq) begin
            st_r <= (st_r == TBT_SQ_ONE) ? TBT_SQ_TWO : TBT_SQ_VALID;
            cnt_r <= 5'h00;
          end else if (cnt_r == 5'(`TBT_SQ_WIN_CYC - 1)) begin
            st_r <= TBT_SQ_IDLE;
          end else begin
            cnt_r <= cnt_r + 5'h01;
          end
        end
        TBT_SQ_VALID: begin
          if (any_sq) begin
            cnt_r <= 5'h00;
          end else if (cnt_r == 5'(`TBT_SQ_EOP_CYC - 1)) begin
            st_r <= TBT_SQ_IDLE;
          end else begin
            cnt_r <= cnt_r + 5'h01;
          end
        end
        default: st_r <= TBT_SQ_IDLE;
      endcase
    end
  end

  AST_SQ_WIN: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st_r == TBT_SQ_ONE || st_r == TBT_SQ_TWO)
      |-> cnt_r < 5'(`TBT_SQ_WIN_CYC))
    else $error("squelch crossing window exceeded");
  AST_SQ_EOP: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(valid) && $past(enable) |-> $past(cnt_r) == 5'(`TBT_SQ_EOP_CYC - 1))
    else $error("valid dropped before squelch gap");
endmodule : tbt_squelch

// >>> design/tbt_port_ctl.sv
// Purpose: 10 Mb/s twisted-pair port control with Wishbone registers
// Assumes: all inputs synchronous to core_clk, one 125 MHz clock
// Notes: long timers count 1 us enable ticks
// Functional notes
// - half duplex: collision on overlap or jabber, carrier on tx and rx
// - full duplex: simultaneous tx and rx, never a collision
// - MAC raises tx enable to start encoding; stops when it falls
// - last transition mid-cell for a final 1, at boundary for 0
// - frame ends when mid-bit transitions stop; carrier off within 1.5 bits
// - valid needs first level, opposite within 150 ns, original within 150 ns
// - valid holds until squelch absent more than 200 ns
// - config bit 10 at index 11h lowers squelch threshold
// - carrier from valid receive; also from transmit in half duplex
// - full duplex and repeater: carrier from receive only
// - MAC collision is tx enable AND recovered carrier, not CRS_DV; here it is tx enable AND crs_r when not full duplex; crs_r also drives mac_crs_dv
// - internal collision exists but is not sent over reduced interface
// - tx enable over 24 ms locks transmitter while it stays high
// - tx enable low about 256 ms before transmit is re-enabled
// - bit 4 at index 10h disables jabber lockout
// - without link pulses, transmitter, receiver and collision are off
// - idle transmitter sends a 100 ns link pulse every 16 ms
// - reversed polarity after 7 inverted pulses or 3 inverted packet ends
// - reversed polarity corrected and flagged at bit 5 of index 10h
// - negotiation picks best common mode, 100 full down to 10 half
// - all rates derived from the one reference clock
// - link-up bit at index 1h muxes 10 and 100 status by speed
//
// Local design decisions: the Wishbone register port and the address map.
`timescale 1ns/100ps
`include "tbt_consts.svh"
module tbt_port_ctl
  import tbt_pkg::*;
#(
  parameter int JAB_TICKS = `TBT_JAB_MS * `TBT_US_PER_MS,
  parameter int UNJAB_TICKS = `TBT_UNJAB_MS * `TBT_US_PER_MS,
  parameter int LP_TICKS = `TBT_LP_MS * `TBT_US_PER_MS,
  parameter int LOSS_TICKS = `TBT_LINK_LOSS_MS * `TBT_US_PER_MS
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic mac_tx_en,
  input wire logic mac_txd,
  output logic tx_line,
  output logic tx_drive,
  output logic lp_out,
  input wire tbt_sq_s sq_in,
  output logic sq_low_thr,
  input wire logic rx_mid,
  input wire logic rx_data,
  input wire tbt_lp_s rx_lp,
  input wire tbt_lp_s rx_eop,
  input wire logic [3:0] partner_abil,
  input wire logic link100_ok,
  output logic mac_rxd,
  output logic mac_rx_dv,
  output logic mac_crs_dv,
  output logic mac_crs,
  output logic mac_col,
  output logic mii_col,
  output logic link_up
);
  logic [15:0] cfg10_r;
  logic [15:0] cfg11_r;
  logic [15:0] ctrl_r;
  logic ack_r;
  logic [31:0] rdat_r;
  logic [6:0] us_cnt_r;
  logic us_tick;
  logic [4:0] hb_acc_r;
  logic hb;
  logic half_r;
  tbt_txst_e tx_st_r;
  logic last_bit_r;
  logic line_r;
  logic jab_r;
  logic [19:0] jab_cnt_r;
  logic [19:0] lp_cnt_r;
  logic [3:0] lpw_r;
  logic [19:0] loss_cnt_r;
  logic link10_r;
  logic sq_valid;
  logic rx_carr_r;
  logic [4:0] gap_r;
  logic crs_r;
  logic col_r;
  logic [2:0] pol_lp_r;
  logic [2:0] pol_eop_r;
  logic pol_rev_r;
  logic rxd_r;
  tbt_mode_e mode;
  logic full_dup;
  logic speed100;
  logic rept;
  logic tx_ok;
  logic tx_act;
  logic [5:0] idx;
  logic wr_en;

  // highest common ability, 100 full first
  function automatic tbt_mode_e best_mode(input logic [3:0] abil);
    tbt_mode_e m;
    m = TBT_M10H;
    if (abil[3]) begin
      m = TBT_M100F;
    end else if (abil[2]) begin
      m = TBT_M100H;
    end else if (abil[1]) begin
      m = TBT_M10F;
    end
    return m;
  endfunction : best_mode

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] lane16(input logic [15:0] old,
                                         input logic [31:0] dat,
                                         input logic [3:0] sel);
    logic [15:0] v;
    v = old;
    if (sel[0]) begin
      v[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      v[15:8] = dat[15:8];
    end
    return v;
  endfunction : lane16

  // mode selection and derived controls
  assign mode = ctrl_r[`TBT_B_ANEN]
    ? best_mode(ctrl_r[`TBT_F_ABIL] & partner_abil)
    : tbt_mode_e'(ctrl_r[`TBT_F_MODE]);
  assign full_dup = (mode == TBT_M10F) || (mode == TBT_M100F);
  assign speed100 = (mode == TBT_M100H) || (mode == TBT_M100F);
  assign rept = ctrl_r[`TBT_B_REPT];
  assign tx_ok = link10_r && !jab_r;
  assign tx_act = (tx_st_r != TBT_TX_IDLE);
  assign link_up = speed100 ? link100_ok : link10_r;
  assign sq_low_thr = cfg11_r[`TBT_B_SQLOW];
  assign idx = wb_adr_i[7:2];
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_r; // lands with ack
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // bus answer one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
    end
  end

  // register writes at the acknowledged edge; unmapped writes are dropped
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cfg10_r <= 16'h0000;
      cfg11_r <= 16'h0000;
      ctrl_r <= `TBT_CTRL_RST;
    end else if (wr_en) begin
      case (idx)
        `TBT_IDX_CFG10: cfg10_r <= lane16(cfg10_r, wb_dat_i, wb_sel_i);
        `TBT_IDX_CFG11: cfg11_r <= lane16(cfg11_r, wb_dat_i, wb_sel_i);
        `TBT_IDX_CTRL: ctrl_r <= lane16(ctrl_r, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
  end

  // read mux, unmapped reads return zero
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdat_r <= 32'h0000_0000;
    end else begin
      rdat_r <= 32'h0000_0000;
      case (idx)
        `TBT_IDX_LSTAT: rdat_r[`TBT_B_LINKUP] <= link_up;
        `TBT_IDX_CFG10: begin
          rdat_r[15:0] <= cfg10_r;
          rdat_r[`TBT_B_POLREV] <= pol_rev_r;
        end
        `TBT_IDX_CFG11: rdat_r[15:0] <= cfg11_r;
        `TBT_IDX_CTRL: rdat_r[15:0] <= ctrl_r;
        `TBT_IDX_STAT: rdat_r[6:0] <= {link10_r, col_r, crs_r, jab_r,
                                         pol_rev_r, mode};
        default: ;
      endcase
    end
  end

  // 1 us tick and 20 MHz half-bit enable from the core clock
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      us_cnt_r <= 7'h00;
      hb_acc_r <= 5'h00;
    end else begin
      us_cnt_r <= us_tick ? 7'h00 : us_cnt_r + 7'h01;
      hb_acc_r <= hb ? hb_acc_r + `TBT_HB_STEP - `TBT_HB_MOD
                     : hb_acc_r + `TBT_HB_STEP;
    end
  end
  assign us_tick = (us_cnt_r == 7'(`TBT_US_CYC - 1));
  assign hb = (hb_acc_r + `TBT_HB_STEP >= `TBT_HB_MOD);

  // manchester encoder: first half ~bit, second half bit
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_st_r <= TBT_TX_IDLE;
      half_r <= 1'b0;
      last_bit_r <= 1'b0;
      line_r <= 1'b0;
    end else if (!tx_ok) begin
      tx_st_r <= TBT_TX_IDLE;
      half_r <= 1'b0;
      line_r <= 1'b0;
    end else if (hb) begin
      case (tx_st_r)
        TBT_TX_IDLE: begin
          if (mac_tx_en) begin
            tx_st_r <= TBT_TX_ACT;
            last_bit_r <= mac_txd;
            line_r <= !mac_txd;
            half_r <= 1'b1;
          end
        end
        TBT_TX_ACT: begin
          if (half_r) begin
            line_r <= last_bit_r;
            half_r <= 1'b0;
          end else if (mac_tx_en) begin
            last_bit_r <= mac_txd;
            line_r <= !mac_txd;
            half_r <= 1'b1;
          end else if (last_bit_r) begin
            tx_st_r <= TBT_TX_IDLE;
          end else begin
            tx_st_r <= TBT_TX_TAIL;
            line_r <= !line_r;
          end
        end
        TBT_TX_TAIL: begin
          tx_st_r <= TBT_TX_IDLE;
          line_r <= 1'b0;
        end
        default: tx_st_r <= TBT_TX_IDLE;
      endcase
    end
  end
  assign tx_line = line_r;
  assign tx_drive = tx_act;

  // jabber lockout and un-jab timer on us ticks
  always_ff @(posedge core_clk) begin
    if (sys_rst || cfg10_r[`TBT_B_JABDIS]) begin
      jab_r <= 1'b0;
      jab_cnt_r <= 20'h00000;
    end else if (!jab_r) begin
      if (!mac_tx_en) begin
        jab_cnt_r <= 20'h00000;
      end else if (us_tick) begin
        if (jab_cnt_r == 20'(JAB_TICKS - 1)) begin
          jab_r <= 1'b1;
          jab_cnt_r <= 20'h00000;
        end else begin
          jab_cnt_r <= jab_cnt_r + 20'h00001;
        end
      end
    end else if (mac_tx_en) begin
      jab_cnt_r <= 20'h00000;
    end else if (us_tick) begin
      if (jab_cnt_r == 20'(UNJAB_TICKS - 1)) begin
        jab_r <= 1'b0;
        jab_cnt_r <= 20'h00000;
      end else begin
        jab_cnt_r <= jab_cnt_r + 20'h00001;
      end
    end
  end

  // idle link pulse generator
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lp_cnt_r <= 20'h00000;
      lpw_r <= 4'h0;
    end else begin
      if (lpw_r != 4'h0) begin
        lpw_r <= lpw_r - 4'h1;
      end
      if (mac_tx_en || tx_act) begin
        lp_cnt_r <= 20'h00000;
      end else if (us_tick) begin
        if (lp_cnt_r == 20'(LP_TICKS - 1)) begin
          lp_cnt_r <= 20'h00000;
          lpw_r <= 4'(`TBT_LP_CYC);
        end else begin
          lp_cnt_r <= lp_cnt_r + 20'h00001;
        end
      end
    end
  end
  assign lp_out = (lpw_r != 4'h0);

  // link integrity from received pulses or valid data
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      link10_r <= 1'b0;
      loss_cnt_r <= 20'h00000;
    end else if (rx_lp.pulse || sq_valid) begin
      link10_r <= 1'b1;
      loss_cnt_r <= 20'h00000;
    end else if (us_tick) begin
      if (loss_cnt_r == 20'(LOSS_TICKS - 1)) begin
        link10_r <= 1'b0;
      end else begin
        loss_cnt_r <= loss_cnt_r + 20'h00001;
      end
    end
  end

  tbt_squelch u_sq (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .sq(sq_in),
    .enable(1'b1),
    .valid(sq_valid)
  );

  // receive carrier: ends when mid-bit transitions stop
  always_ff @(posedge core_clk) begin
    if (sys_rst || !link10_r || !sq_valid) begin
      rx_carr_r <= 1'b0;
      gap_r <= 5'h00;
    end else if (rx_mid) begin
      rx_carr_r <= 1'b1;
      gap_r <= 5'h00;
    end else if (rx_carr_r) begin
      if (gap_r == 5'(`TBT_CRS_DROP_CYC - 1)) begin
        rx_carr_r <= 1'b0;
        gap_r <= 5'h00;
      end else begin
        gap_r <= gap_r + 5'h01;
      end
    end
  end

  // carrier sense and collision
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      crs_r <= 1'b0;
      col_r <= 1'b0;
    end else begin
      crs_r <= rx_carr_r || (tx_act && !full_dup && !rept);
      col_r <= !full_dup && link10_r
               && ((tx_act && rx_carr_r) || jab_r);
    end
  end
  assign mii_col = col_r;
  assign mac_crs = crs_r;
  assign mac_crs_dv = crs_r;
  assign mac_rx_dv = rx_carr_r;
  assign mac_col = mac_tx_en && crs_r && !full_dup;

  // polarity detection; count resets on a normal pulse
  always_ff @(posedge core_clk) begin
    if (sys_rst || !link10_r) begin
      pol_lp_r <= 3'h0;
      pol_eop_r <= 3'h0;
      pol_rev_r <= 1'b0;
    end else begin
      if (rx_lp.pulse) begin
        pol_lp_r <= rx_lp.inv ? pol_lp_r + {2'b00, pol_lp_r != 3'h7}
                              : 3'h0;
        if (rx_lp.inv && pol_lp_r == `TBT_POL_LP_N - 3'h1) begin
          pol_rev_r <= 1'b1;
        end
      end
      if (rx_eop.pulse) begin
        pol_eop_r <= rx_eop.inv ? pol_eop_r + {2'b00, pol_eop_r != 3'h7}
                                : 3'h0;
        if (rx_eop.inv && pol_eop_r == `TBT_POL_EOP_N - 3'h1) begin
          pol_rev_r <= 1'b1;
        end
      end
    end
  end

  // corrected receive data
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rxd_r <= 1'b0;
    end else begin
      rxd_r <= rx_data ^ pol_rev_r;
    end
  end
  assign mac_rxd = rxd_r;

  AST_COL_HALF: assert property (@(posedge core_clk) disable iff (sys_rst)
    !full_dup && link10_r && tx_act && rx_carr_r |=> col_r)
    else $error("no collision on half duplex overlap");
  AST_FD_NOCOL: assert property (@(posedge core_clk) disable iff (sys_rst)
    $past(full_dup) |-> !col_r)
    else $error("collision raised in full duplex");
  AST_CRS_DROP: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(rx_carr_r) && $past(sq_valid) && $past(link10_r)
      |-> $past(gap_r) == 5'(`TBT_CRS_DROP_CYC - 1))
    else $error("receive carrier dropped at wrong time");
  AST_CRS_RXONLY: assert property (@(posedge core_clk) disable iff (sys_rst)
    $past(full_dup || rept) && !$past(rx_carr_r) |-> !crs_r)
    else $error("carrier from transmit in full duplex or repeater");
  AST_JAB_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
    jab_r && mac_tx_en && !cfg10_r[`TBT_B_JABDIS] |=> jab_r)
    else $error("jabber released while tx enable high");
  AST_TX_OFF: assert property (@(posedge core_clk) disable iff (sys_rst)
    !tx_ok |=> tx_st_r == TBT_TX_IDLE)
    else $error("transmitter active without link");
  AST_LP_WIDTH: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(lp_out) |-> lp_out [*8])
    else $error("link pulse too short");
  AST_POL: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(pol_rev_r) |-> $past(pol_lp_r) == `TBT_POL_LP_N - 3'h1
      || $past(pol_eop_r) == `TBT_POL_EOP_N - 3'h1)
    else $error("polarity reversed without enough evidence");
endmodule : tbt_port_ctl

// >>> sim/tbt_partner.sv
// Purpose: remote link partner model on the cable side
// Assumes: comparator levels synchronous to core_clk
// Notes: idle data line toggles; link pulse every 300 cycles
`timescale 1ns/100ps
module tbt_partner
  import tbt_pkg::*;
(
  input wire logic core_clk,
  input wire logic lp_en,
  input wire logic lp_inv,
  output tbt_sq_s sq_in,
  output tbt_lp_s rx_lp,
  output tbt_lp_s rx_eop,
  output logic rx_mid,
  output logic rx_data
);
  logic busy = 1'b0;
  logic [8:0] cnt = 9'h000;
  // quiet line at start
  initial begin
    sq_in = '0;
    rx_lp = '0;
    rx_eop = '0;
    rx_mid = 1'b0;
    rx_data = 1'b0;
  end
  // pulses only between frames; idle data never holds
  always @(posedge core_clk) begin
    cnt <= (cnt == 9'h12B) ? 9'h000 : cnt + 9'h001;
    rx_lp <= '{pulse: lp_en && !busy && cnt == 9'h000, inv: lp_inv};
    if (!busy) rx_data <= ~rx_data;
  end
  // squelch crossings 6 cycles apart, then n bits, end pulse
  task frame(input int n, input logic inv);
    busy = 1'b1;
    @(posedge core_clk);
    sq_in <= 2'b10;
    for (int i = 0; i < 2 * n; i++) begin
      repeat (5) @(posedge core_clk);
      rx_mid <= 1'b0;
      @(posedge core_clk);
      sq_in <= ~sq_in;
      rx_mid <= i[0];
      rx_data <= i[1] ^ i[2];
    end
    @(posedge core_clk);
    rx_mid <= 1'b0;
    rx_eop <= '{pulse: 1'b1, inv: inv};
    sq_in <= '0;
    @(posedge core_clk);
    rx_eop <= '0;
    busy = 1'b0;
  endtask : frame
endmodule : tbt_partner

// >>> sim/tb_tenbase_t_phy_control.sv
// Purpose: self-checking bench for the port control
// Assumes: short timer parameters, 125 MHz clock
// Notes: random stimulus from a fixed-seed shift register
`timescale 1ns/100ps
module tb_tenbase_t_phy_control
  import tbt_pkg::*;
;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic [31:0] rs = 32'h88EE;
  logic wb_ack_o, mac_tx_en = 1'b0, mac_txd = 1'b0, link100_ok = 1'b0;
  logic lp_en = 1'b0, lp_inv = 1'b0, v;
  logic txd_fix = 1'b0, txd_val = 1'b0;
  logic [3:0] partner_abil = 4'hF;
  logic tx_line, tx_drive, lp_out, sq_low_thr, rx_mid, rx_data, mac_rxd;
  logic mac_rx_dv, mac_crs_dv, mac_crs, mac_col, mii_col, link_up;
  tbt_sq_s sq_in;
  tbt_lp_s rx_lp, rx_eop;
  int num_errors = 0, n_checks = 0, n;

  always #4 core_clk = ~core_clk;

  tbt_port_ctl #(.JAB_TICKS(3), .UNJAB_TICKS(4), .LP_TICKS(5),
    .LOSS_TICKS(20)) uut (.core_clk, .sys_rst, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .mac_tx_en, .mac_txd, .tx_line, .tx_drive, .lp_out, .sq_in,
    .sq_low_thr, .rx_mid, .rx_data, .rx_lp, .rx_eop, .partner_abil,
    .link100_ok, .mac_rxd, .mac_rx_dv, .mac_crs_dv, .mac_crs, .mac_col,
    .mii_col, .link_up);
  tbt_partner p (.core_clk, .lp_en, .lp_inv, .sq_in, .rx_lp, .rx_eop,
    .rx_mid, .rx_data);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // best mode common to both ends
  function automatic logic [1:0] best(input logic [3:0] a);
    if (a[3]) return 2'b11;
    if (a[2]) return 2'b10;
    return a[1] ? 2'b01 : 2'b00;
  endfunction : best
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task cycles(input int c);
    repeat (c) @(posedge core_clk);
  endtask : cycles
  // one classic cycle, held until ack is sampled
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge core_clk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  // transmit with a received frame overlapping it
  task txrx(input logic fd);
    partner_abil <= {2'b00, fd, ~fd};
    mac_tx_en <= 1'b1;
    cycles(20);
    chk(tx_drive, 1);
    chk(mac_crs, !fd);
    fork
      p.frame(20, 1'b0);
    join_none
    cycles(100);
    chk(mac_col, !fd);
    chk(mac_crs_dv, 1);
    chk(mac_rx_dv, 1);
    chk(mii_col, !fd);
    mac_tx_en <= 1'b0;
    wait fork;
    n = 0;
    while (mac_crs !== 1'b0 && n < 40) begin
      cycles(1);
      n++;
    end
    chk(n <= 20, 1);
    chk(mac_rx_dv, 0);
    $display("duplex %0d done", fd);
  endtask : txrx
  // frame of constant bits, then the line level as the driver lets go
  task txend(input logic b);
    txd_fix <= 1'b1;
    txd_val <= b;
    mac_tx_en <= 1'b1;
    cycles(40);
    mac_tx_en <= 1'b0;
    n = 0;
    v = 1'b0;
    while (tx_drive === 1'b1 && n < 40) begin
      v = tx_line;
      cycles(1);
      n++;
    end
    chk(v, 1);
    chk(tx_line, b);
    chk(n < 30, 1);
    txd_fix <= 1'b0;
    $display("tx end %0d done", b);
  endtask : txend
  // lockout, restart of the quiet time, disable option
  task jab(input logic dis);
    wb(1, 8'h40, {27'h0, dis, 4'h0});
    mac_tx_en <= 1'b1;
    cycles(520);
    chk(tx_drive, dis);
    chk(mii_col, !dis);
    wb(0, 8'h4C, 0);
    chk(q[3], !dis);
    mac_tx_en <= 1'b0;
    cycles(250);
    mac_tx_en <= 1'b1;
    cycles(20);
    chk(tx_drive, dis);
    mac_tx_en <= 1'b0;
    cycles(680);
    mac_tx_en <= 1'b1;
    cycles(20);
    chk(tx_drive, 1);
    mac_tx_en <= 1'b0;
    $display("jabber %0d done", dis);
  endtask : jab

  always @(posedge core_clk) begin
    rs <= lfsr(rs);
    mac_txd <= txd_fix ? txd_val : rs[3];
  end

  initial begin
    cycles(40000);
    num_errors++;
    end_sim;
  end

  initial begin
    cycles(12);
    sys_rst <= 1'b0;
    wb(0, 8'h48, 0);
    chk(q, 32'h00F1);
    wb(0, 8'hFC, 0);
    chk(q, 0);
    wb(1, 8'h44, 32'h400);
    cycles(2);
    chk(sq_low_thr, 1);
    $display("registers done");
    repeat (12) begin
      partner_abil <= rs[7:4] | 4'h1;
      link100_ok <= rs[9];
      cycles(4);
      wb(0, 8'h4C, 0);
      chk(q[1:0], best(partner_abil));
      chk(link_up, partner_abil[3:2] != 0 && link100_ok);
    end
    $display("negotiation done");
    partner_abil <= 4'h1;
    lp_en <= 1'b1;
    cycles(400);
    wb(0, 8'h4C, 0);
    chk(q[6], 1);
    chk(link_up, 1);
    txrx(0);
    txrx(1);
    txend(1);
    txend(0);
    // forced half duplex with repeater: carrier from receive only
    wb(1, 8'h48, 32'h00F8);
    mac_tx_en <= 1'b1;
    cycles(20);
    chk(tx_drive, 1);
    chk(mac_crs, 0);
    wb(0, 8'h4C, 0);
    chk(q[1:0], 0);
    mac_tx_en <= 1'b0;
    wb(1, 8'h48, 32'h00F1);
    $display("repeater done");
    partner_abil <= 4'h1;
    jab(0);
    jab(1);
    n = 0;
    while (lp_out !== 1'b1 && n < 800) begin
      cycles(1);
      n++;
    end
    chk(n < 760, 1);
    n = 0;
    while (lp_out === 1'b1 && n < 30) begin
      cycles(1);
      n++;
    end
    chk(n, 13);
    $display("link pulse done");
    lp_inv <= 1'b1;
    cycles(2600);
    wb(0, 8'h40, 0);
    chk(q[5], 1);
    v = rx_data;
    cycles(1);
    chk(mac_rxd, !v);
    $display("polarity done");
    lp_en <= 1'b0;
    cycles(2800);
    wb(0, 8'h4C, 0);
    chk(q[6], 0);
    mac_tx_en <= 1'b1;
    cycles(20);
    chk(tx_drive, 0);
    mac_tx_en <= 1'b0;
    $display("link loss done");
    // polarity from inverted end-of-packet pulses
    lp_inv <= 1'b0;
    lp_en <= 1'b1;
    cycles(400);
    wb(0, 8'h4C, 0);
    chk(q[2], 0);
    repeat (3) begin
      p.frame(4, 1'b1);
      cycles(40);
    end
    wb(0, 8'h4C, 0);
    chk(q[2], 1);
    chk(q[6], 1);
    $display("end pulse polarity done");
    end_sim;
  end
endmodule : tb_tenbase_t_phy_control
